/* File: adc_sleep_reset_control.sv */
`timescale 1ns/1ns
// Functional notes
// - rc sleep: finish, then power down unless irq
// - other clocks: sleep aborts and powers down
// - sleep operation only with rc clock code
// - reset clears registers except port directions (set to inputs), off, aborts conversion
// - result bytes not touched by reset
// - bit time from two-bit clock select
// - rc clock: one instruction delay before start
// - done: clear start, load result, set done flag, wake only if asleep with done irq enabled
// - software abort: no load, 2 bit wait
module adc_sleep_reset_control #(
    parameter int RC_DIV = 400,
    parameter int INSTR_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sleep_i,
    input wire logic [9:0] analog_sample_i,
    input wire logic [7:0] port_a_pins_i,
    input wire logic [2:0] port_e_pins_i,
    output logic [2:0] channel_o,
    output logic [3:0] pin_config_o,
    output logic [7:0] port_a_out_o,
    output logic [7:0] port_a_dir_o,
    output logic [2:0] port_e_out_o,
    output logic [2:0] port_e_dir_o,
    output logic converter_powered_o,
    output logic wake_o
);
    import adc_ctl_pkg::*;

    // every control register and the sequencer live in one packed record
    typedef struct packed {
        conv_state_t st;
        logic [7:0] ctrl_main;
        logic [7:0] format_pins;
        logic [7:0] int_ctrl;
        logic [7:0] irq_flags;
        logic [7:0] irq_enables;
        logic [7:0] port_a;
        logic [7:0] port_a_dir;
        logic [7:0] port_e;
        logic [7:0] port_e_dir;
        logic [15:0] div_cnt;
        logic [4:0] bit_cnt;
        logic asleep_off;
        logic wake;
        logic [7:0] rdata;
    } state_t;

    // result bytes live outside the reset struct so no reset touches them
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic load_result;
    logic [15:0] result_word;
    state_t cur;
    state_t nxt;

    ////////////////////////////////////////////////////////////////////////
    // bit time length in system clocks for a given select code
    function automatic logic [15:0] bit_time(input logic [1:0] sel);
        logic [15:0] n;
        // a fallback keeps the result defined for any code
        n = 16'(DIV2_OSC);
        unique case (sel)
            CLK_DIV2: n = 16'(DIV2_OSC);
            CLK_DIV8: n = 16'(DIV8_OSC);
            CLK_DIV32: n = 16'(DIV32_OSC);
            CLK_RC: n = 16'(RC_DIV);
        endcase
        return n;
    endfunction : bit_time

    // place the 10-bit sample left or right in the 16-bit result pair
    function automatic logic [15:0] justify(input logic fmt, input logic [9:0] s);
        return fmt ? {6'h00, s} : {s, 6'h00};
    endfunction : justify

    logic [1:0] clk_sel;
    logic rc_sel;
    logic go_bit;
    logic tick;
    logic conv_busy;
    logic sleep_abort;

    // decoded control fields shared by the sequencer
    assign clk_sel = cur.ctrl_main[POS_CLK_SEL +: 2];
    assign rc_sel = (clk_sel == CLK_RC);
    assign go_bit = cur.ctrl_main[BIT_GO];
    // one system clock left in the current bit time
    assign tick = (cur.div_cnt == 16'h0001);
    // a conversion is under way, either in its start delay or converting
    assign conv_busy = (cur.st == ST_CONVERT) || (cur.st == ST_DELAY);
    // first sleep cycle on a divided clock cuts the converter off
    assign sleep_abort = sleep_i && !rc_sel && !cur.asleep_off;
    // spare bits of the result pair load as zeros on either side
    assign result_word = justify(cur.format_pins[BIT_JUSTIFY], analog_sample_i);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: register writes, then conversion sequencing
    always_comb begin
        nxt = cur;
        load_result = 1'b0;
        nxt.wake = 1'b0;

        // register writes; unimplemented bits are masked off on the way in
        if (wr_i) begin
            unique case (addr_i)
                OFF_CTRL_MAIN: nxt.ctrl_main = wdata_i & MASK_CTRL_MAIN;
                OFF_FORMAT_PINS: nxt.format_pins = wdata_i & MASK_FORMAT_PINS;
                OFF_INT_CTRL: nxt.int_ctrl = wdata_i;
                OFF_IRQ_FLAGS: nxt.irq_flags = wdata_i;
                OFF_IRQ_ENABLES: nxt.irq_enables = wdata_i;
                // port latches keep only the pins that exist; port E direction also keeps bits 7:4
                OFF_PORT_A: nxt.port_a = wdata_i & MASK_PORT_A;
                OFF_PORT_A_DIR: nxt.port_a_dir = wdata_i & MASK_PORT_A;
                OFF_PORT_E: nxt.port_e = wdata_i & MASK_PORT_E;
                OFF_PORT_E_DIR: nxt.port_e_dir = wdata_i & MASK_PORT_E_DIR;
                default: ;
            endcase
        end

        // leaving sleep re-arms the converter power
        if (!sleep_i) begin
            nxt.asleep_off = 1'b0;
        end

        // bit-time divider free-runs and reloads when it reaches one
        if (cur.div_cnt > 16'h0001) begin
            nxt.div_cnt = cur.div_cnt - 16'h0001;
        end else begin
            nxt.div_cnt = bit_time(clk_sel);
        end

        // conversion sequencer
        unique case (cur.st)
            ST_IDLE: begin
                // start only when powered and not shut down by sleep
                if (go_bit && cur.ctrl_main[BIT_POWER] && !cur.asleep_off) begin
                    // the rc clock waits one instruction; divided clocks start at once
                    if (rc_sel) begin
                        nxt.st = ST_DELAY;
                        nxt.bit_cnt = 5'(INSTR_CYCLES);
                    end else begin
                        nxt.st = ST_CONVERT;
                        nxt.bit_cnt = 5'(CONV_BITS);
                        nxt.div_cnt = bit_time(clk_sel);
                    end
                end
            end
            ST_DELAY: begin
                // hold off so the sleep instruction can take effect first
                if (cur.bit_cnt > 5'h01) begin
                    nxt.bit_cnt = cur.bit_cnt - 5'h01;
                end else begin
                    nxt.st = ST_CONVERT;
                    nxt.bit_cnt = 5'(CONV_BITS);
                    nxt.div_cnt = bit_time(clk_sel);
                end
            end
            ST_CONVERT: begin
                // count bit times; the last tick finishes the conversion
                if (tick) begin
                    nxt.bit_cnt = cur.bit_cnt - 5'h01;
                end
                // completion: clear start, load result, raise the done flag
                if (tick && cur.bit_cnt == 5'h01) begin
                    nxt.st = ST_IDLE;
                    nxt.ctrl_main[BIT_GO] = 1'b0;
                    load_result = 1'b1;
                    nxt.irq_flags[BIT_DONE_FLAG] = 1'b1;
                    // finished while asleep: wake if enabled, else power down
                    if (sleep_i) begin
                        if (cur.irq_enables[BIT_DONE_IE]) begin
                            nxt.wake = 1'b1;
                        end else begin
                            nxt.asleep_off = 1'b1;
                        end
                    end
                end
            end
            // settle two bit times after a software abort before a new start
            ST_WAIT: begin
                if (tick) begin
                    nxt.bit_cnt = cur.bit_cnt - 5'h01;
                    if (cur.bit_cnt == 5'h01) begin
                        nxt.st = ST_IDLE;
                    end
                end
            end
        endcase

        // software abort: go cleared mid-conversion, result untouched
        if (conv_busy && !nxt.ctrl_main[BIT_GO] && !load_result) begin
            nxt.st = ST_WAIT;
            nxt.bit_cnt = 5'(ABORT_WAIT_BITS);
            nxt.div_cnt = bit_time(clk_sel);
        end

        // sleep with a non-rc clock aborts; power bit stays set
        if (sleep_abort) begin
            nxt.asleep_off = 1'b1;
            nxt.st = ST_IDLE;
            nxt.ctrl_main[BIT_GO] = 1'b0;
            // a completion cut by the same edge does not raise the done flag; it keeps its old value
            if (load_result) begin
                nxt.irq_flags[BIT_DONE_FLAG] = cur.irq_flags[BIT_DONE_FLAG];
            end
            load_result = 1'b0;
            nxt.wake = 1'b0;
        end

        // power bit cleared: converter off, conversion dropped
        if (!nxt.ctrl_main[BIT_POWER]) begin
            nxt.st = ST_IDLE;
        end

        // read data stand one cycle after the strobe
        nxt.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                OFF_CTRL_MAIN: nxt.rdata = cur.ctrl_main;
                OFF_FORMAT_PINS: nxt.rdata = cur.format_pins;
                OFF_INT_CTRL: nxt.rdata = cur.int_ctrl;
                OFF_IRQ_FLAGS: nxt.rdata = cur.irq_flags;
                OFF_IRQ_ENABLES: nxt.rdata = cur.irq_enables;
                OFF_RES_HIGH: nxt.rdata = res_high;
                OFF_RES_LOW: nxt.rdata = res_low;
                // port reads return pin levels, not the latches
                OFF_PORT_A: nxt.rdata = {2'h0, port_a_pins_i[5:0]};
                OFF_PORT_A_DIR: nxt.rdata = cur.port_a_dir;
                OFF_PORT_E: nxt.rdata = {5'h00, port_e_pins_i};
                OFF_PORT_E_DIR: nxt.rdata = cur.port_e_dir;
                default: nxt.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; reset returns every control register to its value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // result bytes sit outside this record and keep their contents
            cur <= '0;
            // control registers back to their reset values
            cur.st <= ST_IDLE;
            cur.ctrl_main <= RST_CTRL_MAIN;
            cur.format_pins <= RST_FORMAT_PINS;
            cur.int_ctrl <= RST_INT_CTRL;
            cur.irq_flags <= RST_IRQ_FLAGS;
            cur.irq_enables <= RST_IRQ_ENABLES;
            cur.port_a <= RST_PORT_A;
            cur.port_a_dir <= RST_PORT_A_DIR;
            cur.port_e <= RST_PORT_E;
            cur.port_e_dir <= RST_PORT_E_DIR;
        end else begin
            cur <= nxt;
        end
    end

    // result bytes: written by software or on completion, never by reset;
    // a reset edge also blocks a completion or write that falls on it
    always_ff @(posedge clk_i) begin
        if (!rst_i) begin
            if (load_result) begin
                res_high <= result_word[15:8];
                res_low <= result_word[7:0];
            end else if (wr_i && addr_i == OFF_RES_HIGH) begin
                res_high <= wdata_i;
            end else if (wr_i && addr_i == OFF_RES_LOW) begin
                res_low <= wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata_o = cur.rdata;

    // register fields driven straight from the state record
    assign channel_o = cur.ctrl_main[POS_CHANNEL +: 3];
    assign pin_config_o = cur.format_pins[3:0];

    // port latches and directions
    assign port_a_out_o = cur.port_a;
    assign port_a_dir_o = cur.port_a_dir;
    assign port_e_out_o = cur.port_e[2:0];
    assign port_e_dir_o = cur.port_e_dir[2:0];
    // lowest-power state when off or shut down by sleep
    assign converter_powered_o = cur.ctrl_main[BIT_POWER] && !cur.asleep_off;

    // one-cycle wake pulse towards the core
    assign wake_o = cur.wake;
endmodule : adc_sleep_reset_control

/* File: adc_ctl_pkg.sv */
package adc_ctl_pkg;
    // register map (byte offsets on the special function register bus)
    localparam logic [7:0] OFF_PORT_A = 8'h05;
    localparam logic [7:0] OFF_PORT_E = 8'h09;
    localparam logic [7:0] OFF_INT_CTRL = 8'h0B;
    localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_RES_HIGH = 8'h1E;
    localparam logic [7:0] OFF_CTRL_MAIN = 8'h1F;
    localparam logic [7:0] OFF_PORT_A_DIR = 8'h85;
    localparam logic [7:0] OFF_PORT_E_DIR = 8'h89;
    localparam logic [7:0] OFF_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] OFF_RES_LOW = 8'h9E;
    localparam logic [7:0] OFF_FORMAT_PINS = 8'h9F;
    // reset values
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
    localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
    localparam logic [7:0] RST_FORMAT_PINS = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIR = 8'h3F;
    localparam logic [7:0] RST_PORT_E_DIR = 8'h07;
    localparam logic [7:0] RST_PORT_A = 8'h00;
    localparam logic [7:0] RST_PORT_E = 8'h00;
    // implemented-bit masks
    localparam logic [7:0] MASK_CTRL_MAIN = 8'hFD;
    localparam logic [7:0] MASK_FORMAT_PINS = 8'h8F;
    localparam logic [7:0] MASK_PORT_A = 8'h3F;
    localparam logic [7:0] MASK_PORT_E = 8'h07;
    localparam logic [7:0] MASK_PORT_E_DIR = 8'hF7;
    // field positions
    localparam int BIT_POWER = 0;
    localparam int BIT_GO = 2;
    localparam int POS_CHANNEL = 3;
    localparam int POS_CLK_SEL = 6;
    localparam int BIT_JUSTIFY = 7;
    localparam int BIT_DONE_FLAG = 6;
    localparam int BIT_DONE_IE = 6;
    localparam int BIT_GLOBAL_IE = 7;
    localparam int BIT_PERIPH_IE = 6;
    // clock select codes
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC = 2'h3;
    // timing counts in conversion bit times or oscillator periods
    localparam int DIV2_OSC = 2;
    localparam int DIV8_OSC = 8;
    localparam int DIV32_OSC = 32;
    localparam int CONV_BITS = 12;
    localparam int ABORT_WAIT_BITS = 2;
    localparam int RC_START_DELAY = 4;
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONVERT, ST_WAIT} conv_state_t;
endpackage : adc_ctl_pkg

/* File: adc_ctl_properties.sv */
`timescale 1ns/1ns
module adc_ctl_properties
    import adc_ctl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic sleep_i,
    input wire logic [3:0] pin_config_o,
    input wire logic [7:0] port_a_dir_o,
    input wire logic [2:0] port_e_dir_o,
    input wire logic converter_powered_o,
    input wire logic wake_o
);
    logic [1:0] sel;
    logic pwr;
    logic ie;
    wire logic wr_ctrl = wr_i && addr_i == OFF_CTRL_MAIN;
    // shadow of the written fields the properties depend on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel <= CLK_DIV2;
            pwr <= 1'b0;
            ie <= 1'b0;
        end else begin
            sel <= wr_ctrl ? wdata_i[7:6] : sel;
            pwr <= wr_ctrl ? wdata_i[BIT_POWER] : pwr;
            ie <= (wr_i && addr_i == OFF_IRQ_ENABLES) ? wdata_i[BIT_DONE_IE] : ie;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    idle_read_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("stray read data");
    reset_state_a: assert property ($fell(rst_i) |-> pin_config_o == 4'h0
        && port_a_dir_o == RST_PORT_A_DIR && port_e_dir_o == RST_PORT_E_DIR[2:0]
        && !converter_powered_o) else $error("reset state wrong");
    sleep_off_a: assert property (sleep_i && $past(sleep_i) && sel != CLK_RC
        |-> !converter_powered_o) else $error("converter powered in sleep");
    power_off_a: assert property (wr_ctrl && !wdata_i[BIT_POWER]
        |=> !converter_powered_o) else $error("converter on after power bit cleared");
    power_reads_a: assert property (rd_i && addr_i == OFF_CTRL_MAIN
        |=> rdata_o[BIT_POWER] == $past(pwr)) else $error("power bit reads wrong");
    wake_cause_a: assert property (wake_o |-> $past(sleep_i) && ie)
        else $error("wake without sleep or enable");
    wake_pulse_a: assert property (wake_o |=> !wake_o) else $error("wake too long");
    format_out_a: assert property (wr_i && addr_i == OFF_FORMAT_PINS
        |=> {4'h0, pin_config_o} == ($past(wdata_i) & 8'h0F)) else $error("pin config not updated");
endmodule : adc_ctl_properties
bind adc_sleep_reset_control adc_ctl_properties adc_ctl_properties_inst (.clk_i(clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sleep_i(sleep_i), .pin_config_o(pin_config_o),
    .port_a_dir_o(port_a_dir_o), .port_e_dir_o(port_e_dir_o),
    .converter_powered_o(converter_powered_o), .wake_o(wake_o));

/* File: analog_source_model.sv */
`timescale 1ns/1ns
module analog_source_model (
    input wire logic clk_i,
    input wire logic [9:0] level_i,
    output logic [9:0] sample_o,
    output logic [7:0] pins_a_o,
    output logic [2:0] pins_e_o
);
    // input settles one cycle after the bench moves it; pins follow it loosely
    always_ff @(posedge clk_i) begin
        sample_o <= level_i;
        pins_a_o <= level_i[7:0] ^ 8'hA5;
        pins_e_o <= level_i[2:0];
    end
endmodule : analog_source_model

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
    import adc_ctl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [9:0] level = 10'h2C7;
    logic [9:0] old;
    logic [9:0] sample;
    logic [7:0] pins_a;
    logic [2:0] pins_e;
    logic [7:0] rdata_o;
    logic powered;
    logic wake;
    logic [2:0] chan;
    logic [7:0] pa_out;
    logic [2:0] pe_out;
    logic hit;
    logic [7:0] d;
    logic [7:0] hi;
    int bad_count = 0;
    int checked = 0;
    int span [4] = '{24, 96, 384, 52};
    logic [7:0] ra [7] = '{OFF_CTRL_MAIN, OFF_FORMAT_PINS, OFF_IRQ_FLAGS, OFF_IRQ_ENABLES,
        OFF_INT_CTRL, OFF_PORT_A_DIR, OFF_PORT_E_DIR};
    logic [7:0] rv [7] = '{RST_CTRL_MAIN, RST_FORMAT_PINS, RST_IRQ_FLAGS, 8'h00,
        RST_INT_CTRL, RST_PORT_A_DIR, RST_PORT_E_DIR};
    analog_source_model analog_source_model_inst (.clk_i(clk_i), .level_i(level),
        .sample_o(sample), .pins_a_o(pins_a), .pins_e_o(pins_e));
    adc_sleep_reset_control #(.RC_DIV(4), .INSTR_CYCLES(4)) adc_sleep_reset_control_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .analog_sample_i(sample),
        .port_a_pins_i(pins_a), .port_e_pins_i(pins_e), .channel_o(chan), .pin_config_o(),
        .port_a_out_o(pa_out), .port_a_dir_o(), .port_e_out_o(pe_out), .port_e_dir_o(),
        .converter_powered_o(powered), .wake_o(wake));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        // data stand until this edge; taken before the edge updates them
        @(posedge clk_i);
        v = rdata_o;
    endtask : rd
    task start(input logic [1:0] code);
        wr(OFF_CTRL_MAIN, {code, 3'h0, 3'h1});
        wr(OFF_CTRL_MAIN, {code, 3'h0, 3'h5});
    endtask : start
    task give_verdict;
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #300000;
        bad_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], d);
            chk(d, rv[i]);
        end
        wr(8'h40, 8'hFF);
        rd(8'h40, d);
        chk(d, 8'h00);
        for (int c = 0; c < 4; c++) begin
            level <= level + 10'h0F3;
            wr(OFF_FORMAT_PINS, {c[0], 7'h00});
            start(c[1:0]);
            repeat (span[c] - 6) @(posedge clk_i);
            rd(OFF_CTRL_MAIN, d);
            chk(d[BIT_GO], 1'b1);
            repeat (10) @(posedge clk_i);
            rd(OFF_CTRL_MAIN, d);
            chk(d[BIT_GO], 1'b0);
            rd(OFF_IRQ_FLAGS, d);
            chk(d[BIT_DONE_FLAG], 1'b1);
            rd(OFF_RES_HIGH, hi);
            rd(OFF_RES_LOW, d);
            chk({hi, d}, c[0] ? {6'h0, level} : {level, 6'h0});
            wr(OFF_IRQ_FLAGS, 8'h00);
        end
        // software abort keeps the previous result
        old = level;
        start(CLK_DIV32);
        level <= ~level;
        repeat (40) @(posedge clk_i);
        wr(OFF_CTRL_MAIN, {CLK_DIV32, 3'h0, 3'h1});
        repeat (420) @(posedge clk_i);
        rd(OFF_IRQ_FLAGS, d);
        chk(d, 8'h00);
        rd(OFF_RES_LOW, d);
        chk(d, old[7:0]);
        // sleep on a divided clock aborts
        start(CLK_DIV8);
        sleep_i <= 1'b1;
        repeat (120) @(posedge clk_i);
        #1 chk(powered, 1'b0);
        rd(OFF_CTRL_MAIN, d);
        chk(d[2:0], 3'h1);
        rd(OFF_IRQ_FLAGS, d);
        chk(d, 8'h00);
        sleep_i <= 1'b0;
        // sleep on the private clock completes, then powers down
        start(CLK_RC);
        sleep_i <= 1'b1;
        repeat (80) @(posedge clk_i);
        #1 chk(powered, 1'b0);
        rd(OFF_IRQ_FLAGS, d);
        chk(d[BIT_DONE_FLAG], 1'b1);
        rd(OFF_CTRL_MAIN, d);
        chk(d[2:0], 3'h1);
        sleep_i <= 1'b0;
        wr(OFF_IRQ_FLAGS, 8'h00);
        // same with the done interrupt enabled: wake pulse
        wr(OFF_IRQ_ENABLES, 8'h40);
        start(CLK_RC);
        sleep_i <= 1'b1;
        hit = 1'b0;
        repeat (80) begin
            @(posedge clk_i);
            #1 hit = hit | (wake === 1'b1);
        end
        chk(hit, 1'b1);
        chk(powered, 1'b1);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        // reset in mid conversion
        old = level;
        start(CLK_DIV32);
        level <= ~level;
        repeat (30) @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (400) @(posedge clk_i);
        rd(OFF_CTRL_MAIN, d);
        chk(d, 8'h00);
        rd(OFF_IRQ_FLAGS, d);
        chk(d, 8'h00);
        rd(OFF_RES_LOW, d);
        chk(d, old[7:0]);
        chk(powered, 1'b0);
        // fields reach their pins; a power-off write keeps the converter off
        wr(OFF_CTRL_MAIN, {CLK_DIV8, 3'h5, 3'h0});
        wr(OFF_PORT_A, 8'hFF);
        wr(OFF_PORT_E, 8'hFF);
        rd(OFF_PORT_A, d);
        chk(d, {2'h0, level[5:0] ^ 6'h25});
        rd(OFF_PORT_E, d);
        chk(d, {5'h00, level[2:0]});
        chk(chan, 3'h5);
        chk(pa_out, 8'h3F);
        chk(pe_out, 3'h7);
        chk(powered, 1'b0);
        give_verdict();
    end
endmodule : testbench
